// ==== include/dsd_consts.vh ====
`ifndef DSD_CONSTS_VH
`define DSD_CONSTS_VH

// Register byte offsets
`define DSD_AV_CTRL 4'h0
`define DSD_AV_MODE 4'h4
`define DSD_AV_STAT 4'h8
`define DSD_AV_FIFO 4'hc

// Register reset values
`define DSD_CTRL_RST 1'b1
`define DSD_BL8_RST 1'b0
`define DSD_CL_RST 3'h3
`define DSD_AL_RST 3'h0
`define DSD_RTT_RST 2'h0

// Command codes {ras_n, cas_n, we_n}
`define DSD_CMD_MRS 3'h0
`define DSD_CMD_REF 3'h1
`define DSD_CMD_PRE 3'h2
`define DSD_CMD_ACT 3'h3
`define DSD_CMD_WR 3'h4
`define DSD_CMD_RD 3'h5

// Mode register select on bank address
`define DSD_BA_MR 2'h0
`define DSD_BA_EMR1 2'h1

// Address field positions
`define DSD_A_BL_HI 2
`define DSD_A_BL_LO 0
`define DSD_A_CL_HI 6
`define DSD_A_CL_LO 4
`define DSD_A_AL_HI 5
`define DSD_A_AL_LO 3
`define DSD_A_RTT_HI 6
`define DSD_A_RTT_LO 2
`define DSD_A_AP 10
`define DSD_BL8_CODE 3'h3

// Field positions in MODE and STAT
`define DSD_MODE_BL8 0
`define DSD_MODE_CL_LO 1
`define DSD_MODE_AL_LO 4
`define DSD_MODE_RTT_LO 7
`define DSD_ST_OVF 4
`define DSD_ST_NOBANK 5
`define DSD_ST_MODBUSY 6
`define DSD_ST_RDACT 7

// Mode-update window, in link clock cycles
`define DSD_TMOD_CK 4'hc

`endif

// ==== verilog/dsd_lat_pipe.v ====
`timescale 1ns/10ps
module dsd_lat_pipe #(
  parameter W = 6
) (
  input wire clk,
  input wire sys_rst,
  input wire shift,
  input wire [W-1:0] din,
  input wire [3:0] lat,
  output wire [W-1:0] dout
);
  reg [W-1:0] st_q [0:15];
  integer i;

  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < 16; i = i + 1) begin
        st_q[i] <= {W{1'b0}};
      end
    end else if (shift) begin
      st_q[0] <= din;
      for (i = 1; i < 16; i = i + 1) begin
        st_q[i] <= st_q[i-1];
      end
    end
  end

  // Entry pushed at link rise n shows here at link rise n+lat
  assign dout = st_q[lat - 4'h1];
endmodule

// ==== verilog/dsd_fifo.v ====
`timescale 1ns/10ps
module dsd_fifo #(
  parameter W = 13,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire [AW:0] level
);
  localparam [AW:0] DEPTH = D[AW:0];
  reg [W-1:0] buf_q [0:D-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;

  assign level = wp_q - rp_q;
  assign in_ready = level != DEPTH;
  assign out_valid = level != {(AW+1){1'b0}};
  assign out_data = buf_q[rp_q[AW-1:0]];

  always @(posedge clk) begin
    if (sys_rst) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (in_valid && in_ready) begin
      buf_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==== verilog/dsd_ddr2_core.v ====
// Behaviour
// - New termination applies after update window
// - EMRS to EMR1 updates Rtt bits
// - Read latency equals additive plus CAS
// - Write latency is read latency minus one
// - Gapless reads every 2 or 4 clocks
// - Seamless reads across banks when activated
// - Interrupting read may target any bank
// - Auto-precharge read may interrupt a burst
// - Timings use programmed burst length, not actual
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dsd_consts.vh"
module dsd_ddr2_core (
  input wire clk,
  input wire sys_rst,
  input wire ck,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] ba,
  input wire [13:0] addr,
  input wire odt,
  input wire [7:0] dq_i,
  output wire [7:0] dq_o,
  output wire dq_oe,
  input wire dqs_i,
  output wire dqs_o,
  output wire dqs_oe,
  output wire term_en,
  output wire [1:0] term_sel,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest
);
  function [4:0] beat_idx;
    input [1:0] b;
    input [2:0] c;
    input [2:0] n;
    input b8;
    reg [2:0] s;
    begin
      s = c + n;
      beat_idx = b8 ? {b, s} : {b, c[2], s[1:0]};
    end
  endfunction

  // Pin synchroniser: ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq
  reg [29:0] s1_q;
  reg [29:0] s2_q;
  reg [29:0] s3_q;
  reg ck_lvl_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 30'h0;
      s2_q <= 30'h0;
      s3_q <= 30'h0;
      ck_lvl_q <= 1'b0;
    end else begin
      s1_q <= {ck, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q[29] == s3_q[29]) begin
        ck_lvl_q <= s3_q[29];
      end
    end
  end
  wire ck_edge = (s2_q[29] == s3_q[29]) && (s3_q[29] != ck_lvl_q);
  wire ck_rise = ck_edge && s3_q[29];
  wire cs_s = ~s3_q[28];
  wire [2:0] cmd_s = s3_q[27:25];
  wire [1:0] ba_s = s3_q[24:23];
  wire [13:0] addr_s = s3_q[22:9];
  wire odt_s = s3_q[8];
  wire [7:0] dq_s = s3_q[7:0];

  reg en_q;
  reg bl8_q;
  reg [2:0] cl_q;
  reg [2:0] al_q;
  reg [1:0] rtt_q;
  reg [1:0] rtt_new_q;
  reg [3:0] mod_cnt_q;
  reg [3:0] bank_open_q;
  reg [3:0] ap_cnt_q;
  reg [1:0] ap_ba_q;
  reg ovf_q;
  reg nobank_q;

  wire cmd_ok = ck_rise && cs_s && en_q;
  wire cmd_rd = cmd_ok && (cmd_s == `DSD_CMD_RD);
  wire cmd_wr = cmd_ok && (cmd_s == `DSD_CMD_WR);
  wire [3:0] rl = {1'b0, al_q} + {1'b0, cl_q};
  wire [3:0] wl = rl - 4'h1;
  wire [3:0] half_bl = bl8_q ? 4'h4 : 4'h2;

  // Mode registers and the termination update window
  always @(posedge clk) begin
    if (sys_rst) begin
      bl8_q <= `DSD_BL8_RST;
      cl_q <= `DSD_CL_RST;
      al_q <= `DSD_AL_RST;
      rtt_q <= `DSD_RTT_RST;
      rtt_new_q <= `DSD_RTT_RST;
      mod_cnt_q <= 4'h0;
    end else if (cmd_ok && cmd_s == `DSD_CMD_MRS && ba_s == `DSD_BA_MR) begin
      bl8_q <= addr_s[`DSD_A_BL_HI:`DSD_A_BL_LO] == `DSD_BL8_CODE;
      cl_q <= addr_s[`DSD_A_CL_HI:`DSD_A_CL_LO];
    end else if (cmd_ok && cmd_s == `DSD_CMD_MRS && ba_s == `DSD_BA_EMR1) begin
      al_q <= addr_s[`DSD_A_AL_HI:`DSD_A_AL_LO];
      rtt_new_q <= {addr_s[`DSD_A_RTT_HI], addr_s[`DSD_A_RTT_LO]};
      mod_cnt_q <= `DSD_TMOD_CK;
    end else if (ck_rise && mod_cnt_q != 4'h0) begin
      mod_cnt_q <= mod_cnt_q - 4'h1;
      if (mod_cnt_q == 4'h1) begin
        rtt_q <= rtt_new_q;
      end
    end
  end

  // Termination follows ODT only once the new setting has landed
  reg term_en_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      term_en_q <= 1'b0;
    end else begin
      term_en_q <= odt_s && (rtt_q != 2'h0) && (mod_cnt_q == 4'h0);
    end
  end
  assign term_en = term_en_q;
  assign term_sel = rtt_q;

  // Bank state and self-timed precharge after read with auto precharge
  always @(posedge clk) begin
    if (sys_rst) begin
      bank_open_q <= 4'h0;
      ap_cnt_q <= 4'h0;
      ap_ba_q <= 2'h0;
    end else begin
      if (ck_rise && ap_cnt_q != 4'h0) begin
        ap_cnt_q <= ap_cnt_q - 4'h1;
        if (ap_cnt_q == 4'h1) begin
          bank_open_q[ap_ba_q] <= 1'b0;
        end
      end
      if (cmd_ok && cmd_s == `DSD_CMD_ACT) begin
        bank_open_q[ba_s] <= 1'b1;
      end
      if (cmd_ok && cmd_s == `DSD_CMD_PRE) begin
        if (addr_s[`DSD_A_AP]) begin
          bank_open_q <= 4'h0;
        end else begin
          bank_open_q[ba_s] <= 1'b0;
        end
      end
      // Close time counts the programmed length even if cut short
      if (cmd_rd && addr_s[`DSD_A_AP]) begin
        ap_cnt_q <= {1'b0, al_q} + half_bl;
        ap_ba_q <= ba_s;
      end
    end
  end

  // Latency pipes: one entry per link clock, {valid, bank, column}
  wire [5:0] rtap;
  wire [5:0] wtap;
  dsd_lat_pipe #(.W(6)) u_rd_pipe (
    .clk(clk),
    .sys_rst(sys_rst),
    .shift(ck_rise),
    .din(cmd_rd ? {1'b1, ba_s, addr_s[2:0]} : 6'h0),
    .lat(rl),
    .dout(rtap)
  );
  dsd_lat_pipe #(.W(6)) u_wr_pipe (
    .clk(clk),
    .sys_rst(sys_rst),
    .shift(ck_rise),
    .din(cmd_wr ? {1'b1, ba_s, addr_s[2:0]} : 6'h0),
    .lat(wl),
    .dout(wtap)
  );

  // Array storage
  reg [7:0] mem_q [0:31];

  // Read burst engine; a new start simply takes over, which covers both
  // seamless follow-on and a cut-short burst of eight
  reg [1:0] rd_ba_q;
  reg [2:0] rd_col_q;
  reg [2:0] rd_n_q;
  reg [2:0] rd_left_q;
  reg [7:0] dq_q;
  reg dq_oe_q;
  reg dqs_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      rd_ba_q <= 2'h0;
      rd_col_q <= 3'h0;
      rd_n_q <= 3'h0;
      rd_left_q <= 3'h0;
      dq_q <= 8'h0;
      dq_oe_q <= 1'b0;
      dqs_q <= 1'b0;
    end else if (ck_edge) begin
      if (ck_rise && rtap[5]) begin
        rd_ba_q <= rtap[4:3];
        rd_col_q <= rtap[2:0];
        rd_n_q <= 3'h1;
        rd_left_q <= bl8_q ? 3'h7 : 3'h3;
        dq_q <= mem_q[beat_idx(rtap[4:3], rtap[2:0], 3'h0, bl8_q)];
        dq_oe_q <= 1'b1;
        dqs_q <= 1'b1;
      end else if (rd_left_q != 3'h0) begin
        dq_q <= mem_q[beat_idx(rd_ba_q, rd_col_q, rd_n_q, bl8_q)];
        rd_n_q <= rd_n_q + 3'h1;
        rd_left_q <= rd_left_q - 3'h1;
        dqs_q <= ck_rise;
      end else begin
        dq_oe_q <= 1'b0;
        dqs_q <= 1'b0;
      end
    end
  end
  assign dq_o = dq_q;
  assign dq_oe = dq_oe_q;
  assign dqs_o = dqs_q;
  assign dqs_oe = dq_oe_q;

  // Write capture: one beat per link edge from write latency onward
  reg [1:0] wr_ba_q;
  reg [2:0] wr_col_q;
  reg [2:0] wr_n_q;
  reg [2:0] wr_left_q;
  wire wr_start = ck_rise && wtap[5];
  wire wr_beat = ck_edge && (wr_start || wr_left_q != 3'h0);
  wire [4:0] wr_idx = wr_start ? beat_idx(wtap[4:3], wtap[2:0], 3'h0, bl8_q) :
                      beat_idx(wr_ba_q, wr_col_q, wr_n_q, bl8_q);
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ba_q <= 2'h0;
      wr_col_q <= 3'h0;
      wr_n_q <= 3'h0;
      wr_left_q <= 3'h0;
    end else if (wr_start) begin
      wr_ba_q <= wtap[4:3];
      wr_col_q <= wtap[2:0];
      wr_n_q <= 3'h1;
      wr_left_q <= bl8_q ? 3'h7 : 3'h3;
    end else if (wr_beat) begin
      wr_n_q <= wr_n_q + 3'h1;
      wr_left_q <= wr_left_q - 3'h1;
    end
  end

  // Array has one port; read bursts own it, so the write queue waits
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [12:0] fifo_out_data;
  wire [4:0] fifo_level;
  wire drain = fifo_out_valid && !dq_oe_q;
  dsd_fifo #(.W(13), .D(16), .AW(4)) u_wr_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(wr_beat),
    .in_ready(fifo_in_ready),
    .in_data({wr_idx, dq_s}),
    .out_valid(fifo_out_valid),
    .out_ready(!dq_oe_q),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );
  integer k;
  always @(posedge clk) begin
    if (sys_rst) begin
      for (k = 0; k < 32; k = k + 1) begin
        mem_q[k] <= 8'h0;
      end
    end else if (drain) begin
      mem_q[fifo_out_data[12:8]] <= fifo_out_data[7:0];
    end
  end

  // Avalon-MM slave: every access takes two cycles
  reg ack_q;
  reg [31:0] rdata_q;
  wire req = avs_read || avs_write;
  wire wr_acc = avs_write && ack_q;
  wire clr_hit = wr_acc && avs_address == `DSD_AV_STAT;
  assign avs_waitrequest = req && !ack_q;
  assign avs_readdata = rdata_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      en_q <= `DSD_CTRL_RST;
      ovf_q <= 1'b0;
      nobank_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
      if (avs_read && !ack_q) begin
        case (avs_address)
          `DSD_AV_CTRL: rdata_q <= {31'h0, en_q};
          `DSD_AV_MODE: rdata_q <= {23'h0, rtt_q, al_q, cl_q, bl8_q};
          `DSD_AV_STAT: rdata_q <= {24'h0, dq_oe_q, mod_cnt_q != 4'h0, nobank_q, ovf_q, bank_open_q};
          `DSD_AV_FIFO: rdata_q <= {27'h0, fifo_level};
          default: rdata_q <= 32'h0;
        endcase
      end
      if (wr_acc && avs_address == `DSD_AV_CTRL) begin
        en_q <= avs_writedata[0];
      end
      // Sticky flags: a new event wins over a same-cycle clear
      ovf_q <= (wr_beat && !fifo_in_ready) ||
               (ovf_q && !(clr_hit && avs_writedata[`DSD_ST_OVF]));
      nobank_q <= (cmd_rd && !bank_open_q[ba_s]) ||
                  (nobank_q && !(clr_hit && avs_writedata[`DSD_ST_NOBANK]));
    end
  end
endmodule

// ==== dv/dsd_ddr2_core_props.sv ====
`timescale 1ns/10ps
module dsd_ddr2_core_props (
  input wire clk,
  input wire sys_rst,
  input wire odt,
  input wire dq_oe,
  input wire dqs_o,
  input wire dqs_oe,
  input wire term_en,
  input wire [1:0] term_sel,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_one_wait: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait cycle");
  a_ws_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("idle wait");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("readdata moved");
  a_strobe_en: assert property (dqs_oe == dq_oe && (dq_oe || !dqs_o))
    else $error("strobe enable");
  a_burst_first: assert property ($rose(dq_oe) |-> dqs_o ##[1:6] !dqs_o)
    else $error("first beat");
  a_beat_hold: assert property (dq_oe && $changed(dqs_o) |=> $stable(dqs_o) [*3])
    else $error("beat width");
  a_burst_min: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("short burst");
  a_term_low: assert property (!odt [*8] |-> !term_en)
    else $error("term on");
  a_rtt_switch: assert property ($changed(term_sel) |-> !$past(term_en))
    else $error("rtt switch");
endmodule

bind dsd_ddr2_core dsd_ddr2_core_props u_props (.*);

// ==== dv/dsd_ctl_model.sv ====
`timescale 1ns/10ps
`include "dsd_consts.vh"
module dsd_ctl_model (
  input wire clk,
  input wire sys_rst,
  output wire ck,
  output logic cs_n = 1'h1,
  output logic ras_n = 1'h1,
  output logic cas_n = 1'h1,
  output logic we_n = 1'h1,
  output logic [1:0] ba = 2'h0,
  output logic [13:0] addr = 14'h0,
  output logic odt = 1'h0,
  output logic [7:0] dq_i = 8'h0,
  output logic dqs_i = 1'h0
);
  logic [2:0] ph = 3'h0;
  assign ck = ph[2];
  always @(posedge clk) begin
    ph <= sys_rst ? 3'h0 : ph + 3'h1;
  end
  task at(input [2:0] n);
    @(posedge clk);
    while (ph != n) @(posedge clk);
  endtask
  task idle(input int n);
    repeat (n) at(3'h7);
  endtask
  // Changes ride the ck fall, half a period clear of the sampling rise
  task cmd(input [2:0] op, input [1:0] b, input [13:0] a);
    at(3'h7);
    cs_n <= 1'h0;
    {ras_n, cas_n, we_n} <= op;
    ba <= b;
    addr <= a;
    at(3'h7);
    cs_n <= 1'h1;
    {ras_n, cas_n, we_n} <= 3'h7;
    ba <= ~b;
    addr <= ~a;
  endtask
  task emrs(input [13:0] a);
    odt <= 1'h0;
    idle(3);
    cmd(`DSD_CMD_MRS, `DSD_BA_EMR1, a);
    idle(13);
    odt <= 1'h1;
  endtask
  task wr(input [1:0] b, input [2:0] c, input int wl, input logic [31:0] d);
    cmd(`DSD_CMD_WR, b, {11'h0, c});
    repeat (wl) at(3'h1);
    for (int k = 0; k < 4; k++) begin
      dq_i <= d[8 * k +: 8];
      repeat (4) @(posedge clk);
    end
    dq_i <= ~dq_i;
    idle(2);
  endtask
endmodule

// ==== dv/dsd_ddr2_core_tb.sv ====
`timescale 1ns/10ps
`include "dsd_consts.vh"
module dsd_ddr2_core_tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  wire ck, cs_n, ras_n, cas_n, we_n, odt, dqs_i, dq_oe, dqs_o, dqs_oe, term_en, avs_waitrequest;
  wire [1:0] ba, term_sel;
  wire [13:0] addr;
  wire [7:0] dq_i, dq_o;
  wire [31:0] avs_readdata;
  int fails = 0;
  int checks = 0;
  int rises = 0;
  logic [7:0] mem [0:31] = '{default: 8'h0};
  logic [7:0] exq [$];
  logic [7:0] got [$];
  logic [31:0] rd;
  logic oe_q = 1'h0;
  logic dqs_q = 1'h0;
  bit b8;
  dsd_ddr2_core dut (.*);
  dsd_ctl_model m (.*);
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (dq_oe === 1'h1 && (!oe_q || dqs_o !== dqs_q))
      got.push_back(dq_o);
    if (dq_oe === 1'h1 && !oe_q)
      rises++;
    oe_q <= dq_oe === 1'h1;
    dqs_q <= dqs_o;
  end
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(bit w, logic [3:0] a, logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask
  function int idx(int b, int c, int k);
    return b * 8 + (b8 ? (c + k) % 8 : (c & 4) + (c + k) % 4);
  endfunction
  task rdx(int b, int c, bit ap, int nb);
    m.cmd(`DSD_CMD_RD, 2'(b), 14'(c) | {3'h0, ap, 10'h0});
    for (int k = 0; k < nb; k++)
      exq.push_back(mem[idx(b, c, k)]);
  endtask
  // Long settle so the slowest latency and a 16-beat train both finish
  task drain(int nr);
    repeat (128) @(posedge clk);
    chk("beats", exq.size(), got.size());
    chk("bursts", nr, rises);
    foreach (exq[k]) chk("beat", exq[k], got[k]);
    exq = {};
    got = {};
    rises = 0;
  endtask
  task lat(int b, int c, int rl);
    int n;
    n = 0;
    rdx(b, c, 0, 4);
    while (dq_oe !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("latency", 1, n >= rl * 8 - 3 && n <= rl * 8 + 3);
    drain(1);
  endtask
  task setmode(bit l8, int c, int a, logic [1:0] r);
    b8 = l8;
    m.cmd(`DSD_CMD_MRS, `DSD_BA_MR, 14'(c * 16 + (l8 ? 3 : 2)));
    m.emrs(14'(r[1] * 64 + a * 8 + r[0] * 4));
    chk("rtt", r, term_sel);
    repeat (12) @(posedge clk);
    chk("term_en", r != 2'h0, term_en);
    bus(0, `DSD_AV_MODE, 0);
    chk("mode", {r, 3'(a), 3'(c), l8}, rd);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial begin
    int cl, al, c;
    logic [31:0] d;
    void'($urandom(32'hf99aa478));
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (8) @(posedge clk);
    bus(1, `DSD_AV_MODE, 32'h1ff);
    bus(0, `DSD_AV_MODE, 0);
    chk("mode_ro", 32'h6, rd);
    bus(0, `DSD_AV_CTRL, 0);
    chk("ctrl", 32'h1, rd);
    bus(0, 4'h2, 0);
    chk("unmapped", 32'h0, rd);
    for (int b = 0; b < 4; b++)
      m.cmd(`DSD_CMD_ACT, 2'(b), 14'h0);
    bus(0, `DSD_AV_STAT, 0);
    chk("open", 32'hf, rd);
    for (int i = 0; i < 3; i++) begin
      cl = 3 + $urandom_range(2);
      al = $urandom_range(2);
      setmode(0, cl, al, 2'($urandom));
      for (int w = 0; w < 8; w++) begin
        c = $urandom_range(7);
        d = $urandom;
        m.wr(2'(w / 2), 3'(c), al + cl - 1, d);
        for (int j = 0; j < 4; j++)
          mem[idx(w / 2, c, j)] = d[8 * j +: 8];
      end
      lat($urandom_range(3), $urandom_range(7), al + cl);
      rdx(0, $urandom_range(7), 0, 4);
      rdx(3, $urandom_range(7), 0, 4);
      rdx(3, $urandom_range(7), 0, 4);
      drain(1);
    end
    setmode(1, 3, 0, 2'h1);
    rdx(0, 5, 0, 4);
    rdx(1, 2, 1, 8);
    drain(1);
    bus(0, `DSD_AV_STAT, 0);
    chk("ap_close", 32'hd, rd);
    rdx(2, 1, 0, 8);
    m.idle(2);
    rdx(3, 6, 0, 8);
    drain(1);
    rdx(1, 0, 0, 8);
    drain(1);
    bus(0, `DSD_AV_STAT, 0);
    chk("closed", 32'h2d, rd);
    bus(1, `DSD_AV_STAT, 32'h20);
    bus(0, `DSD_AV_STAT, 0);
    chk("w1c", 32'hd, rd);
    // Last reads are long past, so read-to-precharge spacing holds
    m.cmd(`DSD_CMD_PRE, 2'h2, 14'h0);
    bus(0, `DSD_AV_STAT, 0);
    chk("pre_one", 32'h9, rd);
    m.cmd(`DSD_CMD_PRE, 2'h0, 14'h400);
    bus(0, `DSD_AV_STAT, 0);
    chk("pre_all", 32'h0, rd);
    bus(1, `DSD_AV_CTRL, 0);
    rdx(0, 0, 0, 0);
    drain(0);
    bus(0, `DSD_AV_STAT, 0);
    chk("ignored", 32'h0, rd);
    bus(0, `DSD_AV_FIFO, 0);
    chk("level", 32'h0, rd);
    give_verdict;
  end
endmodule
